// >>> include/mks_pkg.sv
// package for the matrix keypad scanner: codes, pin layout and timing
// assumes a 100 MHz ref_clk and a passive 4 x 4 switch matrix outside
package mks_pkg;
    localparam int          MKS_COLS         = 4;
    localparam int          MKS_ROWS         = 4;
    localparam logic [4:0]  MKS_NO_KEY       = 5'h10;
    localparam logic [3:0]  MKS_IND_RESET    = 4'h0;
    localparam logic [7:0]  MKS_DIR_OUT      = 8'h0f;
    localparam int          MKS_CLK_MHZ      = 100;
    localparam int          MKS_DEBOUNCE_MS  = 20;
    localparam int          MKS_DEBOUNCE_CYC =
        MKS_DEBOUNCE_MS * 1000 * MKS_CLK_MHZ;
    localparam int          MKS_SETTLE_CYC   = 3;
    localparam int          MKS_MATCH_CNT    = 2;

    typedef enum logic [2:0]
    {
        MKS_IDLE   = 3'b000,
        MKS_CLEAR  = 3'b001,
        MKS_DRIVE  = 3'b011,
        MKS_SETTLE = 3'b010,
        MKS_TEST   = 3'b110,
        MKS_DONE   = 3'b111
    } mks_state_t;
endpackage : mks_pkg

// >>> src/mks_sync.sv
// two-flop synchroniser for the row sense pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module mks_sync
    import mks_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             clkEn,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else if (clkEn)
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : mks_sync
`default_nettype wire

// >>> src/mks_match.sv
// consecutive-result filter: passes a code only once several scans agree
// assumes one resultValid pulse per finished scan
`timescale 1ns/1ps
`default_nettype none
module mks_match
    import mks_pkg::*;
#(
    parameter int MATCH = MKS_MATCH_CNT
)
(
    // clock, reset and filter enable
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    input  wire logic       enable,
    // scan result
    input  wire logic       resultValid,
    input  wire logic [4:0] resultCode,
    // filtered result
    output logic            outValid,
    output logic      [4:0] outCode
);
    logic [4:0] lastCode;
    logic [7:0] agree;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lastCode <= MKS_NO_KEY;
            agree    <= 8'h00;
        end
        else if (clkEn && resultValid)
        begin
            lastCode <= resultCode;
            if (resultCode == lastCode && agree != 8'hff)
                agree <= agree + 8'h01;
            else if (resultCode != lastCode)
                agree <= 8'h00;
        end
    end

    // disagreement reports the no-press code so the indicator keeps its last value
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            outValid <= 1'b0;
            outCode  <= MKS_NO_KEY;
        end
        else if (clkEn)
        begin
            outValid <= resultValid;
            if (resultValid)
            begin
                if (!enable || (resultCode == lastCode
                    && 32'(agree) + 2 >= MATCH))
                    outCode <= resultCode;
                else
                    outCode <= MKS_NO_KEY;
            end
        end
    end
endmodule : mks_match
`default_nettype wire

// >>> src/mks_scanner.sv
// matrix keypad scanner top: walks a one over the columns, senses rows
// assumes rows read low when open and high when the column one shows
`timescale 1ns/1ps
`default_nettype none
module mks_scanner
    import mks_pkg::*;
#(
    parameter int DEBOUNCE_CYC = MKS_DEBOUNCE_CYC,
    parameter int SETTLE_CYC   = MKS_SETTLE_CYC,
    parameter int MATCH        = MKS_MATCH_CNT
)
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       clkEn,
    // options
    input  wire logic       matchEnable,
    // keypad pins
    input  wire logic [7:0] matrixPortIn,
    output logic      [7:0] matrixPortOut,
    output logic      [7:0] matrixPortOe,
    // indicator and status
    output logic      [3:0] indicatorPort,
    output logic      [4:0] scanCode,
    output logic            scanDone
);
    mks_state_t state;
    logic [3:0] colDrive;
    logic [1:0] colIdx;
    logic [1:0] rowIdx;
    logic [4:0] keyCode;
    logic [7:0] settleCnt;
    logic [31:0] waitCnt;
    logic [3:0] rowSync;
    logic       rowSenseFirst;
    logic       rowSenseSecond;
    logic       rowSenseThird;
    logic       rowSenseFourth;
    logic       rowHit;
    logic       filtValid;
    logic [4:0] filtCode;

    mks_sync #(.WIDTH(MKS_ROWS)) u_sync
    (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn (matrixPortIn[7:4]),
        .syncOut (rowSync)
    );

    assign rowSenseFirst  = rowSync[0];
    assign rowSenseSecond = rowSync[1];
    assign rowSenseThird  = rowSync[2];
    assign rowSenseFourth = rowSync[3];

    always_comb
    begin
        case (rowIdx)
            2'd0:    rowHit = rowSenseFirst;
            2'd1:    rowHit = rowSenseSecond;
            2'd2:    rowHit = rowSenseThird;
            default: rowHit = rowSenseFourth;
        endcase
    end

    // direction register reloaded every scan so a corrupted bit heals
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            matrixPortOe <= MKS_DIR_OUT;
        else if (clkEn && state == MKS_CLEAR)
            matrixPortOe <= MKS_DIR_OUT;
    end

    assign matrixPortOut = {4'h0, colDrive};

    // scan sequencer
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state     <= MKS_IDLE;
            colDrive  <= 4'h0;
            colIdx    <= 2'd0;
            rowIdx    <= 2'd0;
            keyCode   <= 5'h00;
            settleCnt <= 8'h00;
            waitCnt   <= 32'h0;
            scanDone  <= 1'b0;
            scanCode  <= MKS_NO_KEY;
        end
        else if (clkEn)
        begin
            scanDone <= 1'b0;
            case (state)
                MKS_IDLE:
                begin
                    if (waitCnt != 32'h0)
                        waitCnt <= waitCnt - 32'h1;
                    else
                        state <= MKS_CLEAR;
                end
                MKS_CLEAR:
                begin
                    colDrive <= 4'h0;
                    keyCode  <= 5'h00;
                    colIdx   <= 2'd0;
                    state    <= MKS_DRIVE;
                end
                MKS_DRIVE:
                begin
                    colDrive  <= 4'h1 << colIdx;
                    rowIdx    <= 2'd0;
                    settleCnt <= 8'(SETTLE_CYC);
                    state     <= MKS_SETTLE;
                end
                MKS_SETTLE:
                begin
                    // covers the two-flop sync delay plus line settling
                    if (settleCnt != 8'h00)
                        settleCnt <= settleCnt - 8'h01;
                    else
                        state <= MKS_TEST;
                end
                MKS_TEST:
                begin
                    if (rowHit)
                        state <= MKS_DONE;
                    else
                    begin
                        keyCode <= keyCode + 5'h01;
                        if (rowIdx != 2'd3)
                            rowIdx <= rowIdx + 2'd1;
                        else if (colIdx != 2'd3)
                        begin
                            colIdx <= colIdx + 2'd1;
                            state  <= MKS_DRIVE;
                        end
                        else
                            state <= MKS_DONE;
                    end
                end
                MKS_DONE:
                begin
                    scanCode <= keyCode;
                    scanDone <= 1'b1;
                    colDrive <= 4'h0;
                    waitCnt  <= 32'(DEBOUNCE_CYC);
                    state    <= MKS_IDLE;
                end
                default:
                    state <= MKS_IDLE;
            endcase
        end
    end

    mks_match #(.MATCH(MATCH)) u_match
    (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .clkEn       (clkEn),
        .enable      (matchEnable),
        .resultValid (scanDone),
        .resultCode  (scanCode),
        .outValid    (filtValid),
        .outCode     (filtCode)
    );

    // no-press code holds the previous indicator value
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            indicatorPort <= MKS_IND_RESET;
        else if (clkEn && filtValid && filtCode != MKS_NO_KEY)
            indicatorPort <= filtCode[3:0];
    end

    // assertions
    property p_one_col;
        @(posedge ref_clk) disable iff (!reset_n)
        $onehot0(colDrive);
    endproperty
    a_one_col: assert property (p_one_col)
        else $error("more than one column driven");

    property p_clear_first;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_CLEAR) |=> colDrive == 4'h0 && keyCode == 0;
    endproperty
    a_clear_first: assert property (p_clear_first)
        else $error("scan start did not clear columns and code");

    property p_code_pos;
        @(posedge ref_clk) disable iff (!reset_n)
        state == MKS_TEST |-> keyCode == {1'b0, colIdx, rowIdx};
    endproperty
    a_code_pos: assert property (p_code_pos)
        else $error("key code does not match column and row");

    property p_stop_hit;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_TEST && rowHit) |=>
            state == MKS_DONE && $stable(keyCode);
    endproperty
    a_stop_hit: assert property (p_stop_hit)
        else $error("scan did not stop on pressed row");

    property p_range;
        @(posedge ref_clk) disable iff (!reset_n)
        scanDone |-> scanCode <= MKS_NO_KEY;
    endproperty
    a_range: assert property (p_range)
        else $error("scan code out of range");

    property p_nokey;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_TEST && !rowHit && rowIdx == 2'd3
            && colIdx == 2'd3) |=> state == MKS_DONE
            && keyCode == MKS_NO_KEY;
    endproperty
    a_nokey: assert property (p_nokey)
        else $error("empty scan did not give no-press code");

    property p_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (filtValid && filtCode == MKS_NO_KEY) |=> $stable(indicatorPort);
    endproperty
    a_hold: assert property (p_hold)
        else $error("indicator changed on no-press");

    property p_show;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && filtValid && filtCode != MKS_NO_KEY) |=>
            indicatorPort == $past(filtCode[3:0]);
    endproperty
    a_show: assert property (p_show)
        else $error("indicator missed valid code");

    property p_gap;
        @(posedge ref_clk) disable iff (!reset_n)
        (scanDone && DEBOUNCE_CYC > 2) |-> ##1 state == MKS_IDLE [*2];
    endproperty
    a_gap: assert property (p_gap)
        else $error("next scan began without delay");

    property p_dir;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_CLEAR) |=> matrixPortOe == MKS_DIR_OUT;
    endproperty
    a_dir: assert property (p_dir)
        else $error("directions not restored");

    property p_walk;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_DRIVE && colIdx != 2'd0) |=>
            colDrive == {$past(colDrive[2:0]), 1'b0};
    endproperty
    a_walk: assert property (p_walk)
        else $error("column one did not step to the next column");

    property p_key0;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == MKS_TEST && colIdx == 2'd0 && rowIdx == 2'd0) |->
            keyCode == 5'h00;
    endproperty
    a_key0: assert property (p_key0)
        else $error("first key did not start at code zero");

    property p_settle;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && state == MKS_TEST) |->
            $past(state) == MKS_SETTLE || $past(state) == MKS_TEST;
    endproperty
    a_settle: assert property (p_settle)
        else $error("rows tested without a settling wait");

    // shadow of the previous raw result, read only by the filter check
    logic [4:0] prevScan;
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            prevScan <= MKS_NO_KEY;
        else if (clkEn && scanDone)
            prevScan <= scanCode;
    end

    property p_reject;
        @(posedge ref_clk) disable iff (!reset_n)
        (clkEn && scanDone && matchEnable && scanCode != prevScan) |=>
            filtValid && filtCode == MKS_NO_KEY;
    endproperty
    a_reject: assert property (p_reject)
        else $error("disagreeing scan was reported");

    logic [31:0] gapCnt;
    logic        gapArmed;

    // idle cycles since the last finished scan; unarmed after reset
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gapCnt   <= 32'h0;
            gapArmed <= 1'b0;
        end
        else if (clkEn && state == MKS_DONE)
        begin
            gapCnt   <= 32'h0;
            gapArmed <= 1'b1;
        end
        else if (clkEn && state == MKS_IDLE)
            gapCnt <= gapCnt + 32'h1;
    end

    property p_gap_len;
        @(posedge ref_clk) disable iff (!reset_n)
        (state == MKS_CLEAR && gapArmed) |-> gapCnt >= 32'(DEBOUNCE_CYC);
    endproperty
    a_gap_len: assert property (p_gap_len)
        else $error("debounce gap shorter than required");

    c_press: cover property (@(posedge ref_clk)
        scanDone && scanCode < MKS_NO_KEY);
    c_none: cover property (@(posedge ref_clk)
        scanDone && scanCode == MKS_NO_KEY);
    c_key0: cover property (@(posedge ref_clk)
        scanDone && scanCode == 5'h00);
    c_reject: cover property (@(posedge ref_clk)
        matchEnable && filtValid && filtCode == MKS_NO_KEY
        && scanCode != MKS_NO_KEY);
endmodule : mks_scanner
`default_nettype wire

// >>> test/mks_keypad_model.sv
// passive 4 x 4 switch matrix seen from the scanner's pins
// assumes bit 4*column+row of keyDown closes that switch
`timescale 1ns/1ps
`default_nettype none
module mks_keypad_model
    import mks_pkg::*;
(
    // pin side of the scanner
    input  wire logic [7:0]  pinOut,
    input  wire logic [7:0]  pinOe,
    output logic      [7:0]  pinIn,
    // switch state
    input  wire logic [15:0] keyDown
);
    logic [7:0] wireLvl;

    always_comb
    begin
        // released pins sit on pull-downs, so an open row reads low
        wireLvl = pinOut & pinOe;
        pinIn = wireLvl;
        for (int c = 0; c < MKS_COLS; c++)
            for (int r = 0; r < MKS_ROWS; r++)
                if (wireLvl[c] && keyDown[4*c+r])
                    pinIn[4+r] = 1'b1;
    end
endmodule : mks_keypad_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the keypad scanner with a switch matrix model
// assumes short debounce; results are scored in order of scanDone
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mks_pkg::*;
;
    localparam int DB = 20;
    logic        ref_clk = 1'b0;
    logic        reset_n;
    logic        clkEn;
    logic        matchEnable;
    logic [15:0] keys;
    logic [7:0]  matrixPortIn;
    logic [7:0]  matrixPortOut;
    logic [7:0]  matrixPortOe;
    logic [3:0]  indicatorPort;
    logic [4:0]  scanCode;
    logic        scanDone;
    logic [5:0]  expQ[$];
    logic [3:0]  lastInd;
    logic [4:0]  prevCode;
    logic [3:0]  lastOut;
    logic        armed;
    int          idle;
    int          err_total;
    int          samples_checked;

    always #5 ref_clk = ~ref_clk;

    mks_scanner #(.DEBOUNCE_CYC(DB), .SETTLE_CYC(3), .MATCH(2)) mks_scanner_i
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
        .matchEnable(matchEnable), .matrixPortIn(matrixPortIn),
        .matrixPortOut(matrixPortOut), .matrixPortOe(matrixPortOe),
        .indicatorPort(indicatorPort), .scanCode(scanCode),
        .scanDone(scanDone)
    );

    mks_keypad_model mks_keypad_model_i
    (
        .pinOut(matrixPortOut), .pinOe(matrixPortOe),
        .pinIn(matrixPortIn), .keyDown(keys)
    );

    function automatic logic [4:0] first_key(input logic [15:0] k);
        for (int i = 0; i < 16; i++)
            if (k[i])
                return 5'(i);
        return MKS_NO_KEY;
    endfunction : first_key

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // new keys land right after a scan, well ahead of the next one
    task automatic apply(input logic [15:0] k, input logic m);
        @(posedge ref_clk iff scanDone === 1'b1);
        keys <= k;
        matchEnable <= m;
        expQ.push_back({m, first_key(k)});
    endtask : apply

    initial
    begin
        logic [5:0] e;
        forever
        begin
            @(posedge ref_clk iff (scanDone === 1'b1 && reset_n));
            e = (expQ.size() > 0) ? expQ.pop_front() : 6'h3f;
            check({3'h0, scanCode}, {3'h0, e[4:0]});
            if (e[4:0] != MKS_NO_KEY && (!e[5] || e[4:0] == prevCode))
                lastInd = e[3:0];
            prevCode = e[4:0];
            repeat (4) @(posedge ref_clk);
            check({4'h0, indicatorPort}, {4'h0, lastInd});
        end
    end

    always @(posedge ref_clk)
        if (reset_n && clkEn)
        begin
            check(matrixPortOe, MKS_DIR_OUT);
            check({7'h0, $onehot0(matrixPortOut)}, 8'h01);
            if (matrixPortOut[3:0] != lastOut && matrixPortOut[3:0] != 0)
                check({4'h0, matrixPortOut[3:0]},
                      (lastOut == 0) ? 8'h01 : {3'h0, lastOut, 1'b0});
            lastOut = matrixPortOut[3:0];
            if (scanDone)
            begin
                idle = 0;
                armed = 1'b1;
            end
            else if (matrixPortOut == 0)
                idle++;
            else if (armed)
            begin
                check({7'h0, idle >= DB}, 8'h01);
                armed = 1'b0;
            end
        end
        else if (!reset_n)
            armed = 1'b0;

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        summarize();
    end

    initial
    begin
        logic [3:0] held;
        reset_n = 1'b0;
        clkEn = 1'b1;
        matchEnable = 1'b0;
        keys = 16'h0;
        lastInd = MKS_IND_RESET;
        prevCode = MKS_NO_KEY;
        lastOut = 4'h0;
        armed = 1'b0;
        idle = 0;
        err_total = 0;
        samples_checked = 0;
        void'($urandom(96478));
        expQ.push_back({1'b0, MKS_NO_KEY});
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++)
            apply(16'h1 << i, 1'b0);
        apply(16'h8420, 1'b0);
        apply(16'hff00, 1'b0);
        for (int i = 0; i < 8; i++)
            apply(16'($urandom & $urandom), 1'b0);
        apply(16'h0, 1'b0);
        // agreeing and disagreeing scans through the filter
        apply(16'h0020, 1'b1);
        apply(16'h0020, 1'b1);
        apply(16'h0200, 1'b1);
        apply(16'h0, 1'b1);
        apply(16'h0200, 1'b1);
        apply(16'h0200, 1'b1);
        apply(16'h0040, 1'b0);
        // freeze mid-debounce: nothing may move while clkEn is low
        apply(16'h0040, 1'b0);
        repeat (8) @(posedge ref_clk);
        clkEn <= 1'b0;
        @(posedge ref_clk);
        held = matrixPortOut[3:0];
        repeat (60) @(posedge ref_clk);
        check({4'h0, matrixPortOut[3:0]}, {4'h0, held});
        check({7'h0, scanDone}, 8'h00);
        clkEn <= 1'b1;
        // second reset in mid-run
        apply(16'h0001, 1'b0);
        @(posedge ref_clk iff scanDone === 1'b1);
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b0;
        keys <= 16'h0008;
        repeat (2) @(posedge ref_clk);
        check({3'h0, scanCode}, {3'h0, MKS_NO_KEY});
        check({4'h0, indicatorPort}, {4'h0, MKS_IND_RESET});
        expQ.delete();
        expQ.push_back({1'b0, 5'h03});
        lastInd = MKS_IND_RESET;
        prevCode = MKS_NO_KEY;
        reset_n <= 1'b1;
        apply(16'h0, 1'b0);
        @(posedge ref_clk iff scanDone === 1'b1);
        repeat (6) @(posedge ref_clk);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
